// ==== src/fvs_pkg.sv ====
package fvs_pkg;

  // ----------------------------------------
  // widths and channel count
  // ----------------------------------------
  localparam int NUM_CH   = 3;
  localparam int SAMPLE_W = 16;
  localparam int RATIO_W  = 16;
  localparam int PRIM_W   = SAMPLE_W + RATIO_W;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int PREFAULT_MS    = 100;
  localparam int FAULT_EARLY_MS = 10;
  localparam int FAULT_LATE_MS  = 20;
  localparam int SAMPLE_US      = 1000;
  localparam int PREFAULT_SMP   = PREFAULT_MS * 1000 / SAMPLE_US;
  localparam int FAULT_EARLY_SMP = FAULT_EARLY_MS * 1000 / SAMPLE_US;
  localparam int FAULT_LATE_SMP = FAULT_LATE_MS * 1000 / SAMPLE_US;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [PRIM_W-1:0] VALUE_RST = '0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } fvs_samples_t;

  typedef struct packed {
    logic [NUM_CH-1:0][PRIM_W-1:0] preFault;
    logic [NUM_CH-1:0][PRIM_W-1:0] fault;
  } fvs_event_t;

  typedef enum logic [1:0] {
    FVS_IDLE,
    FVS_CAPTURE,
    FVS_ARMED
  } fvs_state_t;

endpackage : fvs_pkg

// ==== src/fvs_fault_value_snapshot.sv ====
`timescale 1ns/1ns
// Operation
// - start edge stores prefault and fault values
// - after capture, wait armed for trip
// - new start overwrites stored captures
// - trip emits events with stored values
// - prefault is value 100 ms before start
// - fault is mean of +10/+20 ms
// - events pushed to list and link unrequested
// - secondary values scaled to primary first
module fvs_fault_value_snapshot #(
  parameter int HIST_DEPTH = fvs_pkg::PREFAULT_SMP + 1
) (
  input  wire logic                                           ref_clk,
  input  wire logic                                           reset,
  input  wire logic                                           clkEn,
  input  wire logic                                           sampleStb,
  input  wire fvs_pkg::fvs_samples_t                          samples,
  input  wire logic [fvs_pkg::NUM_CH-1:0][fvs_pkg::RATIO_W-1:0] ratio,
  input  wire logic                                           capture_arm_input,
  input  wire logic                                           report_trigger_input,
  output logic                                                eventListVld,
  output logic                                                scadaVld,
  output fvs_pkg::fvs_event_t                                 eventData,
  output logic                                                armed
);
  import fvs_pkg::*;

  // refused at elaboration: a shallower history cannot reach back to the prefault sample
  if (HIST_DEPTH < PREFAULT_SMP + 1)
  begin : g_depth_check
    $error("history too shallow for prefault depth");
  end

  localparam int IDX_W = $clog2(HIST_DEPTH);
  localparam int CNT_W = $clog2(FAULT_LATE_SMP + 1);

  // ----------------------------------------
  // primary conversion and history
  // ----------------------------------------
  logic [NUM_CH-1:0][PRIM_W-1:0] prim;
  logic [NUM_CH-1:0][PRIM_W-1:0] hist_r [HIST_DEPTH];
  logic [IDX_W-1:0]              wrIdx_r;
  logic [IDX_W-1:0]              oldIdx;
  logic [IDX_W-1:0]              wrIdxNext;
  logic [NUM_CH-1:0][PRIM_W-1:0] preTap;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_prim
    assign prim[c] = PRIM_W'(samples.ch[c]) * PRIM_W'(ratio[c]);
  end

  assign wrIdxNext = (wrIdx_r == IDX_W'(HIST_DEPTH - 1)) ? '0 : wrIdx_r + 1'b1;
  // next write goes to wrIdx_r; newest sample is one slot back, prefault one span further
  assign oldIdx = (wrIdx_r >= IDX_W'(PREFAULT_SMP + 1)) ? wrIdx_r - IDX_W'(PREFAULT_SMP + 1)
                : IDX_W'(int'(wrIdx_r) + HIST_DEPTH - PREFAULT_SMP - 1);
  assign preTap = hist_r[oldIdx];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      wrIdx_r <= '0;
    else if (clkEn && sampleStb)
      wrIdx_r <= wrIdxNext;
  end

  // history has no reset: it refills within one prefault span and stays plain flops
  always_ff @(posedge ref_clk)
  begin
    if (clkEn && sampleStb)
      hist_r[wrIdx_r] <= prim;
  end

  // ----------------------------------------
  // edge, window and capture control
  // ----------------------------------------
  fvs_state_t                    state_r;
  logic                          startDly_r;
  logic [CNT_W-1:0]              smpCnt_r;
  logic [NUM_CH-1:0][PRIM_W-1:0] pre_r;
  logic [NUM_CH-1:0][PRIM_W-1:0] early_r;
  logic [NUM_CH-1:0][PRIM_W-1:0] flt_r;
  logic                          tripPend_r;
  logic                          startEdge;
  logic                          lateHit;
  logic                          earlyHit;
  logic                          fireNow;
  logic [NUM_CH-1:0][PRIM_W:0]   fltSum;
  logic [NUM_CH-1:0][PRIM_W-1:0] fltMean;

  assign startEdge = capture_arm_input && !startDly_r;
  assign earlyHit  = sampleStb && (smpCnt_r == CNT_W'(FAULT_EARLY_SMP - 1));
  assign lateHit   = sampleStb && (smpCnt_r == CNT_W'(FAULT_LATE_SMP - 1));
  // early trip held until the late sample lands
  assign fireNow   = (state_r == FVS_ARMED && report_trigger_input)
                   || (state_r == FVS_CAPTURE && lateHit && tripPend_r);

  // extra bit keeps the carry of the sum; dropping bit 0 halves it, truncating
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_mean
    assign fltSum[c]  = {1'b0, early_r[c]} + {1'b0, prim[c]};
    assign fltMean[c] = fltSum[c][PRIM_W:1];
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r      <= FVS_IDLE;
      startDly_r   <= 1'b0;
      smpCnt_r     <= '0;
      pre_r        <= '0;
      early_r      <= '0;
      flt_r        <= '0;
      tripPend_r   <= 1'b0;
      eventListVld <= 1'b0;
      scadaVld     <= 1'b0;
      eventData    <= '0;
      armed        <= 1'b0;
    end
    else if (clkEn)
    begin
      startDly_r   <= capture_arm_input;
      eventListVld <= fireNow;
      scadaVld     <= fireNow;
      if (fireNow)
      begin
        eventData.preFault <= pre_r;
        eventData.fault    <= (state_r == FVS_CAPTURE) ? fltMean : flt_r;
      end
      if (startEdge)
      begin
        // a fresh start discards any earlier capture and pending trip; a trip firing in this same cycle still reports the old capture
        pre_r      <= preTap;
        smpCnt_r   <= '0;
        tripPend_r <= 1'b0;
        state_r    <= FVS_CAPTURE;
        armed      <= 1'b1;
      end
      else
      begin
        case (state_r)
          FVS_IDLE:
            armed <= 1'b0;
          FVS_CAPTURE:
          begin
            if (report_trigger_input)
              tripPend_r <= 1'b1;
            if (sampleStb)
              smpCnt_r <= smpCnt_r + 1'b1;
            if (earlyHit)
              early_r <= prim;
            if (lateHit)
            begin
              flt_r   <= fltMean;
              state_r <= fireNow ? FVS_IDLE : FVS_ARMED;
              armed   <= !fireNow;
            end
          end
          FVS_ARMED:
            if (report_trigger_input)
            begin
              state_r <= FVS_IDLE;
              armed   <= 1'b0;
            end
          default:
            state_r <= FVS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_trip_idle_silent;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && state_r == FVS_IDLE && !startEdge) |=> !eventListVld;
  endproperty
  a_trip_idle_silent: assert property (p_trip_idle_silent)
    else $error("event emitted without stored capture");

  property p_both_links;
    @(posedge ref_clk) disable iff (reset)
      eventListVld == scadaVld;
  endproperty
  a_both_links: assert property (p_both_links)
    else $error("event list and link disagree");

  property p_armed_trip_fires;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && state_r == FVS_ARMED && report_trigger_input && !startEdge)
        |=> eventListVld && !armed;
  endproperty
  a_armed_trip_fires: assert property (p_armed_trip_fires)
    else $error("armed trip did not report");

  property p_start_arms;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && startEdge) |=> armed && state_r == FVS_CAPTURE;
  endproperty
  a_start_arms: assert property (p_start_arms)
    else $error("start edge did not arm");

  property p_no_early_report;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && state_r == FVS_CAPTURE && !lateHit) |=> !eventListVld;
  endproperty
  a_no_early_report: assert property (p_no_early_report)
    else $error("report before fault average");

  property p_prefault_take;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && startEdge) |=> pre_r == $past(preTap);
  endproperty
  a_prefault_take: assert property (p_prefault_take)
    else $error("prefault not taken from the delayed slot");

  property p_fault_mean;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && state_r == FVS_CAPTURE && lateHit && !startEdge)
        |=> flt_r == $past(fltMean);
  endproperty
  a_fault_mean: assert property (p_fault_mean)
    else $error("fault value is not the window mean");

endmodule : fvs_fault_value_snapshot

// ==== sim/fvs_prot_model.sv ====
`timescale 1ns/1ns
// ------------------------------
// protection start and trip source
// ------------------------------
module fvs_prot_model (
  input  wire logic ref_clk,
  input  wire logic startCmd,
  input  wire logic tripCmd,
  output logic      startOut,
  output logic      tripOut
);
  initial
  begin
    startOut = 1'b0;
    tripOut  = 1'b0;
  end

  // levels move only after the falling edge, clear of the sampling edge
  always @(negedge ref_clk)
  begin
    startOut <= startCmd;
    tripOut  <= tripCmd;
  end
endmodule : fvs_prot_model

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
  import fvs_pkg::*;
  logic                           ref_clk   = 1'b0;
  logic                           reset     = 1'b1;
  logic                           clkEn     = 1'b1;
  logic                           sampleStb = 1'b0;
  fvs_samples_t                   samples   = '0;
  logic [NUM_CH-1:0][RATIO_W-1:0] ratio     = {16'h5, 16'h3, 16'h2};
  logic                           startCmd  = 1'b0;
  logic                           tripCmd   = 1'b0;
  logic                           startLvl;
  logic                           tripLvl;
  logic                           eventListVld;
  logic                           scadaVld;
  logic                           armed;
  fvs_event_t                     eventData;
  int                             mismatches  = 0;
  int                             comparisons = 0;
  int                             smpCnt      = 0;
  int                             phase       = 3;
  int                             s0;
  int                             s1;

  fvs_prot_model fvs_prot_model_i (.ref_clk(ref_clk), .startCmd(startCmd), .tripCmd(tripCmd),
    .startOut(startLvl), .tripOut(tripLvl));
  fvs_fault_value_snapshot fvs_fault_value_snapshot_i (.ref_clk(ref_clk), .reset(reset),
    .clkEn(clkEn), .sampleStb(sampleStb), .samples(samples), .ratio(ratio),
    .capture_arm_input(startLvl), .report_trigger_input(tripLvl),
    .eventListVld(eventListVld), .scadaVld(scadaVld), .eventData(eventData), .armed(armed));

  always #4 ref_clk = ~ref_clk;

  // one sample set every fourth cycle, values a known function of the index
  always @(negedge ref_clk)
  begin
    phase = (phase + 1) % 4;
    sampleStb <= (phase == 0);
    if (phase == 0)
    begin
      for (int c = 0; c < NUM_CH; c++)
        samples.ch[c] <= smpVal(smpCnt, c);
      smpCnt = smpCnt + 1;
    end
  end

  function automatic logic [SAMPLE_W-1:0] smpVal(int i, int c);
    return SAMPLE_W'(i * 7 + c * 3 + 1);
  endfunction : smpVal

  function automatic logic [PRIM_W-1:0] prim(int i, int c);
    return PRIM_W'(smpVal(i, c)) * PRIM_W'(ratio[c]);
  endfunction : prim

  function automatic fvs_event_t expect_ev(int s);
    fvs_event_t e;
    for (int c = 0; c < NUM_CH; c++)
    begin
      e.preFault[c] = prim(s - 1 - PREFAULT_SMP, c);
      e.fault[c] = PRIM_W'(((PRIM_W + 1)'(prim(s + FAULT_EARLY_SMP - 1, c))
                   + (PRIM_W + 1)'(prim(s + FAULT_LATE_SMP - 1, c))) / 2);
    end
    return e;
  endfunction : expect_ev

  task automatic check(logic [$bits(fvs_event_t)-1:0] got, logic [$bits(fvs_event_t)-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // ------------------------------
  // scenarios
  // ------------------------------
  // start lands two edges after a strobe, so the newest sample is unambiguous
  task automatic arm(output int s);
    do @(posedge ref_clk); while (phase != 0);
    s = smpCnt;
    @(negedge ref_clk);
    startCmd <= 1'b1;
    @(negedge ref_clk);
    startCmd <= 1'b0;
    @(negedge ref_clk);
    check(armed, 1'b1);
  endtask : arm

  task automatic trip_report(int s, bit expectEv);
    int n;
    tripCmd <= 1'b1;
    for (n = 0; n < 200 && eventListVld !== 1'b1; n++)
      @(negedge ref_clk);
    if (expectEv)
    begin
      check(n < 200, 1'b1);
      check(eventData, expect_ev(s));
      check({scadaVld, armed, smpCnt >= s + FAULT_LATE_SMP}, 3'h5);
    end
    else
      check(n, 200);
    @(negedge ref_clk);
    tripCmd <= 1'b0;
    check(eventListVld, 1'b0);
    // let the low level stand an edge before any next call raises it again
    @(negedge ref_clk);
  endtask : trip_report

  // a trip during a clock-enable freeze must wait, with the capture kept
  task automatic frozen_trip(int s);
    clkEn   <= 1'b0;
    tripCmd <= 1'b1;
    repeat (8) @(negedge ref_clk);
    check({eventListVld, armed}, 2'h1);
    clkEn <= 1'b1;
    trip_report(s, 1'b1);
  endtask : frozen_trip

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset <= 1'b0;
    trip_report(0, 1'b0);
    wait (smpCnt > PREFAULT_SMP + 5);
    arm(s0);
    trip_report(s0, 1'b1);
    trip_report(0, 1'b0);
    arm(s0);
    repeat (4 * 30) @(negedge ref_clk);
    arm(s1);
    repeat (4 * 40) @(negedge ref_clk);
    frozen_trip(s1);
    print_verdict();
  end
endmodule : tb
